/* File: logic/framer_alarm_regs.vh */
`ifndef FRAMER_ALARM_REGS_VH
`define FRAMER_ALARM_REGS_VH

// register word indices, and byte addresses at four times the index
`define IDX_ERR_INSERT_CTRL   8'h12
`define IDX_INT_ENABLE        8'h1A
`define IDX_STATUS            8'h1C
`define IDX_CHANGE_LATCH      8'h1D
`define IDX_MASTER_ENABLE     8'h1E
`define IDX_LINE_MODE         8'h1F
`define ADDR_ERR_INSERT_CTRL  12'h048
`define ADDR_INT_ENABLE       12'h068
`define ADDR_STATUS           12'h070
`define ADDR_CHANGE_LATCH     12'h074
`define ADDR_MASTER_ENABLE    12'h078
`define ADDR_LINE_MODE        12'h07C

// error insert control fields
`define EIC_TYPE_MSB          4
`define EIC_FTYPE_LSB         5
`define EIC_MANUAL_BIT        7
`define EIC_RESET             8'h00

// status layout
`define ST_NO_SIGNAL          0
`define ST_ALIGN_CHANGE       7
`define STATUS_USED_MASK      8'h3F
`define LATCH_USED_MASK       8'hBF
`define INT_ENABLE_RESET      8'h00
`define LATCH_RESET           8'h00
`define MASTER_GLOBAL_BIT     0
`define LINE_DUAL_RAIL_BIT    0
`define LINE_MODE_RESET       8'h01

`endif

/* File: logic/rise_detect.v */
`timescale 1ns/1ps
`default_nettype none
// flags rising edges of a vector, one cycle pulse per bit
module rise_detect #(
	parameter W = 5
) (
	input  wire         clk,     // system clock
	input  wire         reset_n, // async reset
	input  wire [W-1:0] level,   // levels watched
	output wire [W-1:0] rise     // one-cycle rise pulses
);
	reg [W-1:0] prev_ff;

	// remember last value
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_ff <= {W{1'b0}};
		end else begin
			prev_ff <= level;
		end
	end

	assign rise = level & ~prev_ff;
endmodule // rise_detect
`default_nettype wire

/* File: logic/framer_alarm_status_interrupt.v */
// Behaviour
// - manual select 0: each 0-to-1 of a type control bit inserts one error
// - manual select 1: strobe rising edge inserts errors for types held at 1
// - all type control bits 0: no errors inserted at all
// - six real-time status bits in fixed order, bits 0 to 5
// - no-signal from own detector in dual-rail mode, external interface otherwise
// - remote alarm reflects only X/Sa bits, never far-end channel codes
// - latched bits 0-5 set on any change of real-time status
// - latched bits clear only by writing one; zero leaves them
// - interrupt when latched bit, its enable and global enable are set
// - interrupt drops once latch, enable or global enable clears
// - alignment-change latch set on resync at a different alignment
// - after clear, not set again until sync lost and regained elsewhere
// - enable bits for positions 0-5 and 7, reset to zero
//
// Design decision made here: the APB slave port.
`include "framer_alarm_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module framer_alarm_status_interrupt (
	input  wire        clk,                       // 40 MHz system clock
	input  wire        reset_n,                   // async reset, active low
	input  wire        psel,                      // apb select
	input  wire        penable,                   // apb access phase
	input  wire        pwrite,                    // apb write
	input  wire [11:0] paddr,                     // apb byte address
	input  wire [31:0] pwdata,                    // apb write data
	output reg  [31:0] prdata,                    // apb read data
	output reg         pready,                    // apb ready
	output reg         pslverr,                   // apb error
	input  wire        no_signal_detect,          // own detector, dual-rail
	input  wire        no_signal_external,        // from line interface, binary
	input  wire        frame_sync_missing_status, // out-of-frame condition
	input  wire        alarm_indication_status,   // alarm indication condition
	input  wire        remote_alarm_xsa,          // remote alarm from X/Sa bits
	input  wire        idle_pattern_status,       // idle condition
	input  wire        severe_frame_error_status, // severe frame error condition
	input  wire        sync_acquired,             // pulse: framer gained sync
	input  wire [11:0] sync_alignment,            // alignment at that sync
	input  wire        manual_error_strobe,       // pin, async
	output reg         bipolar_violation_insert,  // one-cycle insert pulse
	output reg         excess_zero_insert,        // one-cycle insert pulse
	output reg         parity_bit_error_insert,   // one-cycle insert pulse
	output reg         cbit_parity_error_insert,  // one-cycle insert pulse
	output reg         framing_bit_error_insert,  // one-cycle insert pulse
	output reg  [1:0]  framing_error_type_select, // framing error kind
	output reg         irq                        // level interrupt
);
	reg  [7:0]  err_ctrl_ff;
	reg  [7:0]  int_en_ff;
	reg  [7:0]  latch_ff;
	reg  [7:0]  nxt_latch;
	reg  [5:0]  status_ff;
	reg         global_en_ff;
	reg         dual_rail_ff;
	reg         strobe_s1_ff;
	reg         strobe_s2_ff;
	reg         strobe_s3_ff;
	reg         nsx_s1_ff;
	reg         nsx_s2_ff;
	reg         have_sync_ff;
	reg         armed_ff;
	reg  [11:0] last_align_ff;
	reg  [4:0]  nxt_insert;
	wire [4:0]  ctrl_rise;
	wire [5:0]  status_now;
	wire        wr_en;
	wire        rd_en;
	wire        wr_strobe;
	wire        strobe_rise;
	wire        realign_event;
	wire [7:0]  wbyte;
	wire        sel_err_ctrl;
	wire        sel_int_en;
	wire        sel_status;
	wire        sel_latch;
	wire        sel_master;
	wire        sel_line;
	wire        sel_mapped;
	wire [7:0]  nxt_int_en;
	wire        nxt_global_en;

	// address decode helper
	function hit;
		input [11:0] a;
		input [11:0] b;
		begin
			hit = (a == b);
		end
	endfunction

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite; // read data captured at setup
	assign wr_strobe = wr_en & pready;        // the one edge a write lands
	assign wbyte = pwdata[7:0];

	// one select per register, shared by bus, write and clear logic
	assign sel_err_ctrl = hit(paddr, `ADDR_ERR_INSERT_CTRL);
	assign sel_int_en   = hit(paddr, `ADDR_INT_ENABLE);
	assign sel_status   = hit(paddr, `ADDR_STATUS);
	assign sel_latch    = hit(paddr, `ADDR_CHANGE_LATCH);
	assign sel_master   = hit(paddr, `ADDR_MASTER_ENABLE);
	assign sel_line     = hit(paddr, `ADDR_LINE_MODE);
	assign sel_mapped   = sel_err_ctrl | sel_int_en | sel_status | sel_latch
		| sel_master | sel_line;

	// apb slave: zero wait, error on unmapped
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~sel_mapped;
			prdata  <= 32'h00000000;
			if (rd_en) begin
				case (1'b1)
					sel_err_ctrl: prdata[7:0] <= err_ctrl_ff;
					sel_int_en:   prdata[7:0] <= int_en_ff;
					sel_status:   prdata[7:0] <= {2'b00, status_ff};
					sel_latch:    prdata[7:0] <= latch_ff;
					sel_master:   prdata[0]   <= global_en_ff;
					sel_line:     prdata[0]   <= dual_rail_ff;
					default:      prdata      <= 32'h00000000;
				endcase
			end
		end
	end

	// next enable values, so the interrupt follows an enable write at once
	assign nxt_int_en = (wr_strobe & sel_int_en) ?
		(wbyte & `LATCH_USED_MASK) : int_en_ff;
	assign nxt_global_en = (wr_strobe & sel_master) ?
		wbyte[`MASTER_GLOBAL_BIT] : global_en_ff;

	// write side of control registers; pready high marks the access edge
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			err_ctrl_ff  <= `EIC_RESET;
			int_en_ff    <= `INT_ENABLE_RESET;
			global_en_ff <= 1'b0;
			dual_rail_ff <= 1'b1;
		end else begin
			int_en_ff    <= nxt_int_en;
			global_en_ff <= nxt_global_en;
			if (wr_strobe & sel_err_ctrl)
				err_ctrl_ff <= wbyte;
			if (wr_strobe & sel_line)
				dual_rail_ff <= wbyte[`LINE_DUAL_RAIL_BIT];
		end
	end

	// synchronise strobe pin and external no-signal
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strobe_s1_ff <= 1'b0;
			strobe_s2_ff <= 1'b0;
			strobe_s3_ff <= 1'b0;
			nsx_s1_ff    <= 1'b0;
			nsx_s2_ff    <= 1'b0;
		end else begin
			strobe_s1_ff <= manual_error_strobe;
			strobe_s2_ff <= strobe_s1_ff;
			strobe_s3_ff <= strobe_s2_ff;
			nsx_s1_ff    <= no_signal_external;
			nsx_s2_ff    <= nsx_s1_ff;
		end
	end

	assign strobe_rise = strobe_s2_ff & ~strobe_s3_ff;

	// rising edges of the per-type control bits
	rise_detect #(
		.W(5)
	) u_ctrl_rise (
		.clk     (clk),
		.reset_n (reset_n),
		.level   (err_ctrl_ff[`EIC_TYPE_MSB:0]),
		.rise    (ctrl_rise)
	);

	// select insert trigger; zero controls give no pulse either way
	always @* begin
		if (err_ctrl_ff[`EIC_MANUAL_BIT])
			nxt_insert = {5{strobe_rise}} & err_ctrl_ff[`EIC_TYPE_MSB:0];
		else
			nxt_insert = ctrl_rise;
	end

	// insert pulse outputs
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bipolar_violation_insert  <= 1'b0;
			excess_zero_insert        <= 1'b0;
			parity_bit_error_insert   <= 1'b0;
			cbit_parity_error_insert  <= 1'b0;
			framing_bit_error_insert  <= 1'b0;
			framing_error_type_select <= 2'b00;
		end else begin
			bipolar_violation_insert  <= nxt_insert[0];
			excess_zero_insert        <= nxt_insert[1];
			parity_bit_error_insert   <= nxt_insert[2];
			cbit_parity_error_insert  <= nxt_insert[3];
			framing_bit_error_insert  <= nxt_insert[4];
			framing_error_type_select <= err_ctrl_ff[`EIC_FTYPE_LSB+1:`EIC_FTYPE_LSB];
		end
	end

	// real-time status in fixed order
	assign status_now = {severe_frame_error_status, idle_pattern_status,
		remote_alarm_xsa,
		alarm_indication_status, frame_sync_missing_status,
		(dual_rail_ff ? no_signal_detect : nsx_s2_ff)};

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status_ff <= 6'h00;
		end else begin
			status_ff <= status_now;
		end
	end

	// alignment change: armed on sync loss, fires on a new alignment
	assign realign_event = sync_acquired & have_sync_ff & armed_ff
		& (sync_alignment != last_align_ff);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			have_sync_ff  <= 1'b0;
			armed_ff      <= 1'b1;
			last_align_ff <= 12'h000;
		end else begin
			if (sync_acquired) begin
				have_sync_ff  <= 1'b1;
				last_align_ff <= sync_alignment;
				armed_ff      <= 1'b0;
			end else if (status_ff[1]) begin
				armed_ff <= 1'b1;
			end
		end
	end

	// latched changes, set wins over write-one clear
	always @* begin
		nxt_latch = latch_ff;
		if (wr_strobe & sel_latch)
			nxt_latch = latch_ff & ~wbyte;
		nxt_latch[5:0] = nxt_latch[5:0] | (status_now ^ status_ff);
		if (realign_event)
			nxt_latch[`ST_ALIGN_CHANGE] = 1'b1;
		nxt_latch = nxt_latch & `LATCH_USED_MASK;
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			latch_ff <= `LATCH_RESET;
		end else begin
			latch_ff <= nxt_latch;
		end
	end

	// interrupt from next-state values so it drops with the clear
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= nxt_global_en & (|(nxt_latch & nxt_int_en));
		end
	end
endmodule // framer_alarm_status_interrupt
`default_nettype wire

/* File: test/alarm_irq_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module alarm_irq_properties (
	input wire logic        clk,     // clock
	input wire logic        reset_n, // reset
	input wire logic        psel,    // select
	input wire logic        penable, // access
	input wire logic        pwrite,  // write
	input wire logic [11:0] paddr,   // address
	input wire logic [31:0] pwdata,  // write data
	input wire logic [31:0] prdata,  // read data
	input wire logic        pready,  // ready
	input wire logic        pslverr, // error
	input wire logic        irq      // interrupt
);
	// one clock domain for all checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire rd_ok = pready && !pwrite;
	wire wr_ok = pready && pwrite;
	// bus timing, refusals, unused bits, interrupt gating
	property p_rdy; psel && !penable |=> pready && psel && penable; endproperty
	a_rdy: assert property (p_rdy) else $error("ready late");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_slv; pslverr |-> pready && penable; endproperty
	a_slv: assert property (p_slv) else $error("error outside access");
	property p_err; pready && paddr > 12'h07C |-> pslverr && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("unmapped not refused");
	property p_unu; rd_ok && (paddr == 12'h068 || paddr == 12'h074)
		|-> prdata[31:8] == 24'h0 && !prdata[6]; endproperty
	a_unu: assert property (p_unu) else $error("unused bit set");
	property p_sts; rd_ok && paddr == 12'h070 |-> prdata[31:6] == 26'h0; endproperty
	a_sts: assert property (p_sts) else $error("status high bits set");
	property p_glb; wr_ok && paddr == 12'h078 && !pwdata[0] |=> !irq [*2]; endproperty
	a_glb: assert property (p_glb) else $error("irq with global off");
	property p_ien; wr_ok && paddr == 12'h068 && pwdata[7:0] == 8'h00 |=> !irq; endproperty
	a_ien: assert property (p_ien) else $error("irq with enables off");
	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
	c_clr: cover property ($fell(irq));
endmodule // alarm_irq_properties
bind framer_alarm_status_interrupt alarm_irq_properties u_props (.clk(clk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

/* File: test/apb_host.sv */
`timescale 1ns/1ps
`default_nettype none
module apb_host (
	input  wire logic        clk,     // clock
	output var  logic        psel,    // select
	output var  logic        penable, // access
	output var  logic        pwrite,  // write
	output var  logic [11:0] paddr,   // address
	output var  logic [31:0] pwdata,  // write data
	input  wire logic [31:0] prdata,  // read data
	input  wire logic        pready,  // ready
	input  wire logic        pslverr, // error
	output var  logic        hang     // no answer
);
	logic err_seen;
	// idle bus from time zero
	initial begin
		{psel, penable, pwrite, hang} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// setup then access, held until ready is sampled
	task xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, 24'h0, d};
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!pready && n < 20);
		hang <= !pready;
		q = prdata[7:0];
		err_seen = pslverr;
		{psel, penable} <= 2'h0;
	endtask
endmodule // apb_host
`default_nettype wire

/* File: test/framer_alarm_status_interrupt_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module framer_alarm_status_interrupt_tb;
	logic        clk = 1'h0, reset_n = 1'h0, ext = 1'h0, sa = 1'h0, stb = 1'h0;
	logic [5:0]  cv = 6'h00;
	logic [11:0] al = 12'h000;
	logic [7:0]  q;
	wire         psel, penable, pwrite, pready, pslverr, irq, hang;
	wire  [11:0] paddr;
	wire  [31:0] pwdata, prdata;
	wire  [4:0]  ins;
	wire  [1:0]  fsel;
	int          bad_count = 0, tests_run = 0, ic [5];
	logic [15:0] rows [8] = '{16'h0101, 16'h0302, 16'h0704, 16'h0F08, 16'h1F10, 16'h3F20,
		16'h2A15, 16'h002A};
	// clock and insert pulse counters
	always #12.5 clk = ~clk;
	always @(posedge clk)
		for (int i = 0; i < 5; i++)
			ic[i] <= ic[i] + ins[i];
	always @(posedge hang) begin
		bad_count++;
		end_sim();
	end
	apb_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hang(hang));
	framer_alarm_status_interrupt u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .no_signal_detect(cv[0]), .no_signal_external(ext),
		.frame_sync_missing_status(cv[1]), .alarm_indication_status(cv[2]),
		.remote_alarm_xsa(cv[3]), .idle_pattern_status(cv[4]),
		.severe_frame_error_status(cv[5]), .sync_acquired(sa), .sync_alignment(al),
		.manual_error_strobe(stb), .bipolar_violation_insert(ins[0]),
		.excess_zero_insert(ins[1]), .parity_bit_error_insert(ins[2]),
		.cbit_parity_error_insert(ins[3]), .framing_bit_error_insert(ins[4]),
		.framing_error_type_select(fsel), .irq(irq));
	// compare, bus wrappers, waits
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", s, e, g);
			bad_count++;
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		u_host.xfer(1'h1, a, d, q);
	endtask
	task rd(input logic [11:0] a, input logic [7:0] e, input string s);
		u_host.xfer(1'h0, a, 8'h00, q);
		chk(s, e, q);
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task sync(input logic [11:0] a);
		@(posedge clk);
		{sa, al} <= {1'h1, a};
		@(posedge clk);
		sa <= 1'h0;
		tick(3);
	endtask
	task strobe;
		@(posedge clk);
		stb <= 1'h1;
		tick(3);
		stb <= 1'h0;
		tick(8);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// reset, row loop, then hand-written cases
	initial begin
		tick(6);
		reset_n <= 1'h1;
		rd(12'h07C, 8'h01, "line mode");
		rd(12'h068, 8'h00, "enable");
		wr(12'h068, 8'hFF);
		rd(12'h068, 8'hBF, "enable");
		wr(12'h078, 8'h01);
		foreach (rows[i]) begin
			@(posedge clk);
			cv <= rows[i][13:8];
			tick(3);
			rd(12'h070, rows[i][15:8], "status");
			rd(12'h074, rows[i][7:0], "latch");
			chk("irq", 8'h01, {7'h0, irq});
			wr(12'h074, rows[i][7:0]);
			rd(12'h074, 8'h00, "latch");
			chk("irq", 8'h00, {7'h0, irq});
		end
		wr(12'h07C, 8'h00);
		ext <= 1'h1;
		tick(4);
		rd(12'h070, 8'h01, "status");
		chk("status", 8'h01, q & 8'hEF);
		wr(12'h074, 8'h00);
		rd(12'h074, 8'h01, "latch");
		wr(12'h078, 8'h00);
		rd(12'h070, 8'h01, "status");
		chk("irq", 8'h00, {7'h0, irq});
		wr(12'h078, 8'h01);
		wr(12'h07C, 8'h01);
		wr(12'h074, 8'hFF);
		sync(12'h005);
		cv <= 6'h02;
		tick(2);
		cv <= 6'h00;
		sync(12'h009);
		rd(12'h074, 8'h82, "latch");
		chk("irq", 8'h01, {7'h0, irq});
		wr(12'h068, 8'h00);
		tick(1);
		chk("irq", 8'h00, {7'h0, irq});
		wr(12'h068, 8'hFF);
		wr(12'h074, 8'hFF);
		sync(12'h003);
		rd(12'h074, 8'h00, "latch");
		wr(12'h048, 8'h7F);
		tick(4);
		for (int i = 0; i < 5; i++) chk("insert", 8'h01, ic[i][7:0]);
		chk("type", 8'h03, {6'h00, fsel});
		wr(12'h048, 8'h80);
		strobe();
		wr(12'h048, 8'h82);
		strobe();
		for (int i = 0; i < 5; i++) chk("insert", {7'h0, i == 1} + 8'h01, ic[i][7:0]);
		@(posedge clk);
		cv <= 6'h04;
		tick(3);
		chk("irq", 8'h01, {7'h0, irq});
		reset_n <= 1'h0;
		cv <= 6'h00;
		tick(2);
		chk("irq", 8'h00, {7'h0, irq});
		reset_n <= 1'h1;
		rd(12'h068, 8'h00, "enable");
		rd(12'h074, 8'h00, "latch");
		rd(12'h07C, 8'h01, "line mode");
		rd(12'h048, 8'h00, "insert ctrl");
		chk("slverr", 8'h00, {7'h0, u_host.err_seen});
		rd(12'h0F0, 8'h00, "unmapped");
		chk("slverr", 8'h01, {7'h0, u_host.err_seen});
		end_sim();
	end
endmodule // framer_alarm_status_interrupt_tb
`default_nettype wire
